/* File: verilog/bcs_bus_start.v */
// Bus cycle start controller: starts, qualifies and ends external bus cycles
// How it works
// - Accept 8, 16 or 32-bit ports by handshake.
// - Asynchronous inputs pass an internal synchroniser.
// - Sampled async levels always resolve high or low.
// - Synchronous termination means 32-bit port, no synchroniser.
// - Start drives address, size, space, direction, early strobe.
// - Cache hit, translation miss, fault abort before strobe.
// - Operand start strobe only on first cycle.
// - Three-bit space code valid while strobe asserted.
// - Size outputs give bytes remaining during strobe.
// - Direction changes only at start, when different.
// - Lock asserted first cycle until last completes.
// - Lock negated before state 0 of next cycle ends.
// - 32 address lines valid while strobe asserted.
// - Address strobe asserted one state after start.
// - Acknowledge pair encodes wait or port width.
//
// One core_clk period is one bus state (half a bus clock), so the
// strobe that follows the start by half a bus clock is one edge later.
// Acknowledge pins are caught on the falling edge and settled on
// the next rising edge; synchronous inputs are read as they stand,
// which is why only 32-bit ports may use them.
`timescale 1ns/1ps
`include "bcs_defines.vh"

module bcs_bus_start #(
  parameter ADDR_W = 32,
  parameter SPACE_W = 3
) (
  input wire core_clk, // Processor clock, 50 MHz
  input wire reset_n, // Asynchronous reset, active low
  input wire req_valid, // Core asks for a bus cycle
  input wire [ADDR_W-1:0] req_addr, // Address of first byte
  input wire [1:0] req_size, // Bytes remaining code
  input wire [SPACE_W-1:0] req_space, // Address space code
  input wire req_write, // 1 write, 0 read
  input wire req_cache_inhibit, // Do not cache this access
  input wire req_first, // First cycle of an operand
  input wire req_locked, // Cycle belongs to a locked sequence
  input wire req_locked_last, // Last cycle of the locked sequence
  input wire cache_hit, // On-chip cache holds the item
  input wire translation_miss, // Translation cache missed
  input wire mapper_fault, // Memory mapper reports a fault
  input wire async_ack0_n, // Asynchronous acknowledge 0 pin
  input wire async_ack1_n, // Asynchronous acknowledge 1 pin
  input wire sync_terminate_n, // Synchronous termination pin
  input wire burst_ack_n, // Burst acknowledge pin
  input wire cache_inhibit_in_n, // Cache inhibit input pin
  output reg req_ready, // Sequencer idle, request may be taken
  output reg cycle_done, // Pulse: cycle terminated
  output reg cycle_aborted, // Pulse: cycle abandoned before strobe
  output reg [1:0] port_size, // Port width of the ended cycle
  output reg ended_sync, // Ended cycle used synchronous termination
  output reg burst_granted, // Burst acknowledge seen at end
  output reg inhibit_seen, // Cache inhibit seen at end
  output reg early_cycle_start_n, // Early cycle start strobe
  output reg operand_start_n, // Operand start strobe
  output reg address_strobe_n, // Address strobe
  output reg [SPACE_W-1:0] space_code, // Address space code
  output reg xfer_size_lo, // Size code, low bit
  output reg xfer_size_hi, // Size code, high bit
  output reg read_write, // Direction, high read, low write
  output reg cache_inhibit_out_n, // Cache inhibit output
  output reg locked_sequence_n, // Locked sequence strobe
  output reg [ADDR_W-1:0] addr_lines // Address bus
);

  // ==========================================================
  // Functions
  // ==========================================================

  // Map acknowledge pair to port width
  function [1:0] ack_port;
    input [1:0] ack;
    begin
      case (ack)
        `BCS_ACK_8: ack_port = `BCS_PORT_8;
        `BCS_ACK_16: ack_port = `BCS_PORT_16;
        `BCS_ACK_32: ack_port = `BCS_PORT_32;
        default: ack_port = `BCS_PORT_NONE;
      endcase
    end
  endfunction

  // Either termination path ends the strobed cycle
  function ends_cycle;
    input sync_n;
    input ack_end;
    begin
      ends_cycle = !sync_n || ack_end;
    end
  endfunction

  // ==========================================================
  // Input sampling
  // ==========================================================

  wire [1:0] ack_sync;
  wire [1:0] ack_port_now;
  wire async_end;
  wire abort_now;

  // Acknowledge pins resolved to clean levels before use
  bcs_sync2 #(
    .WIDTH(2)
  ) u_ack_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in({async_ack1_n, async_ack0_n}),
    .sync_out(ack_sync)
  );

  assign ack_port_now = ack_port(ack_sync);
  assign async_end = (ack_sync != `BCS_ACK_WAIT);
  assign abort_now = cache_hit | translation_miss | mapper_fault;

  // Synchronous inputs skip the synchroniser: the far side holds
  // them steady around every rising edge while the strobe is low

  // ==========================================================
  // Sequencer state
  // ==========================================================

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg lock_last_ff;
  reg nxt_lock_last;

  // Next state
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      `BCS_ST_IDLE: begin
        if (req_valid) begin
          nxt_state = `BCS_ST_START;
        end
      end
      `BCS_ST_START: begin
        if (abort_now) begin
          nxt_state = `BCS_ST_IDLE;
        end else begin
          nxt_state = `BCS_ST_STROBE;
        end
      end
      `BCS_ST_STROBE: begin
        if (ends_cycle(sync_terminate_n, async_end)) begin
          nxt_state = `BCS_ST_IDLE;
        end
      end
      default: nxt_state = `BCS_ST_IDLE;
    endcase
  end

  // Remember whether this cycle closes the locked sequence
  always @* begin
    nxt_lock_last = lock_last_ff;
    if (state_ff == `BCS_ST_IDLE && req_valid) begin
      nxt_lock_last = req_locked & req_locked_last;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= `BCS_ST_IDLE;
      lock_last_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      lock_last_ff <= nxt_lock_last;
    end
  end

  // ==========================================================
  // Bus outputs
  // ==========================================================

  wire take_req;
  wire start_abort;
  wire term_now;

  assign take_req = (state_ff == `BCS_ST_IDLE) && req_valid;
  assign start_abort = (state_ff == `BCS_ST_START) && abort_now;
  assign term_now = (state_ff == `BCS_ST_STROBE) && ends_cycle(sync_terminate_n, async_end);

  // Address and space code set only at cycle start
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_lines <= `BCS_ADDR_RESET;
      space_code <= `BCS_SPACE_RESET;
    end else if (take_req) begin
      addr_lines <= req_addr;
      space_code <= req_space;
    end
  end

  // Size code of the bytes still to move, set at cycle start
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      xfer_size_lo <= 1'b0;
      xfer_size_hi <= 1'b0;
    end else if (take_req) begin
      xfer_size_lo <= req_size[0];
      xfer_size_hi <= req_size[1];
    end
  end

  // Direction turns only when the new cycle reverses it
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      read_write <= 1'b1;
    end else if (take_req && (read_write == req_write)) begin
      read_write <= ~req_write;
    end
  end

  // Cache inhibit output travels with the start
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cache_inhibit_out_n <= 1'b1;
    end else if (take_req) begin
      cache_inhibit_out_n <= ~req_cache_inhibit;
    end
  end

  // Start strobes last exactly one state
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      early_cycle_start_n <= 1'b1;
      operand_start_n <= 1'b1;
    end else begin
      early_cycle_start_n <= ~take_req;
      operand_start_n <= ~(take_req & req_first);
    end
  end

  // Address strobe follows an unaborted start by one state
  // Outside logic keyed on the early start waits for this strobe,
  // since an abort in the start state leaves it high
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      address_strobe_n <= 1'b1;
    end else if (state_ff == `BCS_ST_START && !abort_now) begin
      address_strobe_n <= 1'b0;
    end else if (term_now) begin
      address_strobe_n <= 1'b1;
    end
  end

  // Locked sequence: set at first cycle, released when last ends
  // A plain request releases a lock left by an aborted last cycle,
  // so the following cycle never starts locked by mistake
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      locked_sequence_n <= 1'b1;
    end else if (take_req && req_locked) begin
      locked_sequence_n <= 1'b0;
    end else if (take_req && !req_locked) begin
      locked_sequence_n <= 1'b1;
    end else if (term_now && lock_last_ff) begin
      locked_sequence_n <= 1'b1;
    end
  end

  // ==========================================================
  // Core-side answers
  // ==========================================================

  // Termination report; synchronous end means a 32-bit port
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cycle_done <= 1'b0;
      cycle_aborted <= 1'b0;
      port_size <= `BCS_PORT_NONE;
      ended_sync <= 1'b0;
      burst_granted <= 1'b0;
      inhibit_seen <= 1'b0;
    end else begin
      cycle_done <= term_now;
      cycle_aborted <= start_abort;
      if (term_now) begin
        if (!sync_terminate_n) begin
          port_size <= `BCS_PORT_32;
          ended_sync <= 1'b1;
        end else begin
          port_size <= ack_port_now;
          ended_sync <= 1'b0;
        end
        burst_granted <= ~burst_ack_n;
        inhibit_seen <= ~cache_inhibit_in_n;
      end
    end
  end

  // Ready when the sequencer will be idle next state
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (nxt_state == `BCS_ST_IDLE);
    end
  end

endmodule

/* File: verilog/bcs_defines.vh */
// Constants for the bus cycle start controller
`ifndef BCS_DEFINES_VH
`define BCS_DEFINES_VH

// State codes of the cycle sequencer
`define BCS_ST_IDLE 2'h0
`define BCS_ST_START 2'h1
`define BCS_ST_STROBE 2'h2

// Bytes-remaining size codes {hi,lo}
`define BCS_SIZE_FOUR 2'h0
`define BCS_SIZE_ONE 2'h1
`define BCS_SIZE_TWO 2'h2
`define BCS_SIZE_THREE 2'h3

// Port size codes reported at termination
`define BCS_PORT_NONE 2'h0
`define BCS_PORT_8 2'h1
`define BCS_PORT_16 2'h2
`define BCS_PORT_32 2'h3

// Acknowledge pair {ack1,ack0} meanings
`define BCS_ACK_WAIT 2'h3
`define BCS_ACK_8 2'h2
`define BCS_ACK_16 2'h1
`define BCS_ACK_32 2'h0

// Reset levels of the bus outputs
`define BCS_ADDR_RESET 32'h0000_0000
`define BCS_SPACE_RESET 3'h0
`define BCS_SYNC_RESET 1'h1

// Synchroniser depth on asynchronous inputs
`define BCS_SYNC_STAGES 2

`endif

/* File: verilog/bcs_sync2.v */
// Two-stage synchroniser for asynchronous input levels
`timescale 1ns/1ps

module bcs_sync2 #(
  parameter WIDTH = 2
) (
  input wire core_clk, // Processor clock
  input wire reset_n, // Asynchronous reset, active low
  input wire [WIDTH-1:0] async_in, // Level from a pin
  output wire [WIDTH-1:0] sync_out // Level resolved to core_clk
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] stable_ff;

  // First stage catches the pin on the falling edge; inputs idle high
  always @(negedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= {WIDTH{1'b1}};
    end else begin
      meta_ff <= async_in;
    end
  end

  // Second stage settles the level on the rising edge; only it is read
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stable_ff <= {WIDTH{1'b1}};
    end else begin
      stable_ff <= meta_ff;
    end
  end

  assign sync_out = stable_ff;

endmodule

/* File: sim/bcs_bus_start_checker.sv */
// Assertions for the bus cycle start controller
`timescale 1ns/1ps
module bcs_bus_start_checker #(
  parameter ADDR_W = 32,
  parameter SPACE_W = 3
) (
  input wire core_clk, // Clock
  input wire reset_n, // Reset
  input wire req_ready, // Idle
  input wire cycle_done, // End pulse
  input wire cycle_aborted, // Abort pulse
  input wire [1:0] port_size, // Port width
  input wire sync_terminate_n, // Sync end
  input wire early_cycle_start_n, // Early start
  input wire operand_start_n, // Operand start
  input wire address_strobe_n, // Strobe
  input wire [SPACE_W-1:0] space_code, // Space
  input wire xfer_size_lo, // Size lo
  input wire xfer_size_hi, // Size hi
  input wire read_write, // Direction
  input wire [ADDR_W-1:0] addr_lines // Address
);
  // ==========
  // Cycle properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_strobe_or_abort: assert property
    (!early_cycle_start_n |=> (!address_strobe_n) != cycle_aborted) else $error("no strobe after start");
  a_start_pulse: assert property
    (!early_cycle_start_n |-> address_strobe_n ##1 early_cycle_start_n) else $error("bad start pulse");
  a_operand_start: assert property
    (!operand_start_n |-> !early_cycle_start_n) else $error("operand strobe alone");
  a_control_held: assert property
    (!address_strobe_n |=> address_strobe_n || $stable({addr_lines, space_code, xfer_size_hi, xfer_size_lo,
     read_write})) else $error("control moved in strobe");
  a_dir_at_start: assert property
    ($changed(read_write) |-> !early_cycle_start_n) else $error("direction moved late");
  a_busy_refuse: assert property
    (!address_strobe_n || !early_cycle_start_n |-> !req_ready) else $error("ready while busy");
  a_end_after_strobe: assert property
    (cycle_done |-> address_strobe_n && $past(!address_strobe_n)) else $error("end without strobe");
  a_sync_ends_32: assert property
    (!address_strobe_n && !sync_terminate_n |=> cycle_done && port_size == 2'h3) else $error("sync end bad");
  a_abort_no_strobe: assert property
    (cycle_aborted |-> address_strobe_n && !$past(early_cycle_start_n)) else $error("abort late");
  c_abort: cover property (cycle_aborted);
  c_sync: cover property (!address_strobe_n && !sync_terminate_n);
  c_byte_port: cover property (cycle_done && port_size == 2'h1);
endmodule

bind bcs_bus_start bcs_bus_start_checker #(.ADDR_W(ADDR_W), .SPACE_W(SPACE_W)) u_chk (.core_clk, .reset_n,
  .req_ready, .cycle_done, .cycle_aborted, .port_size, .sync_terminate_n, .early_cycle_start_n,
  .operand_start_n, .address_strobe_n, .space_code, .xfer_size_lo, .xfer_size_hi, .read_write, .addr_lines);

/* File: sim/bcs_port_model.sv */
// Far-side port model answering bus cycles
`timescale 1ns/1ps
module bcs_port_model (
  input wire core_clk, // Processor clock
  input wire address_strobe_n, // Cycle qualifier
  input wire [2:0] reply, // Bit 2 sync end, else ack pair
  input wire [1:0] delay, // Wait states before answer
  output reg async_ack0_n = 1'h1, // Ack 0, pulled up
  output reg async_ack1_n = 1'h1, // Ack 1, pulled up
  output reg sync_terminate_n = 1'h1, // Sync end
  output reg burst_ack_n = 1'h1, // Burst ack
  output reg cache_inhibit_in_n = 1'h1 // Inhibit in
);
  reg [1:0] cnt = 2'h0;
  // Answer only strobed cycles, changing off the rising edge
  always @(negedge core_clk) begin
    if (address_strobe_n) begin
      cnt <= 2'h0;
      {async_ack1_n, async_ack0_n, sync_terminate_n, burst_ack_n, cache_inhibit_in_n} <= 5'h1F;
    end else if (cnt == delay) begin
      if (reply[2]) begin
        {sync_terminate_n, burst_ack_n, cache_inhibit_in_n} <= 3'h0;
      end else begin
        {async_ack1_n, async_ack0_n} <= reply[1:0];
      end
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule

/* File: sim/bcs_bus_start_tb.sv */
// Self-checking bench for the bus cycle start controller
`timescale 1ns/1ps
module bcs_bus_start_tb;
  reg core_clk = 1'h0, reset_n = 1'h0, req_valid = 1'h0;
  reg [31:0] req_addr = 32'h0;
  reg [1:0] req_size = 2'h0, delay = 2'h0;
  reg [2:0] req_space = 3'h0, abort_in = 3'h0, reply = 3'h0;
  reg req_write = 1'h0, req_cache_inhibit = 1'h0, req_first = 1'h0, req_locked = 1'h0, req_locked_last = 1'h0;
  wire req_ready, cycle_done, cycle_aborted, ended_sync, early_cycle_start_n, operand_start_n, address_strobe_n;
  wire xfer_size_lo, xfer_size_hi, read_write, cache_inhibit_out_n, locked_sequence_n, burst_granted, inhibit_seen;
  wire async_ack0_n, async_ack1_n, sync_terminate_n, burst_ack_n, cache_inhibit_in_n;
  wire [1:0] port_size;
  wire [2:0] space_code;
  wire [31:0] addr_lines;
  integer n_fail = 0, check_count = 0, seed = 32'hB567278F, k, i;
  // ==========
  // Clock, design and far side
  always #10 core_clk = ~core_clk;
  bcs_bus_start dut (.core_clk, .reset_n, .req_valid, .req_addr, .req_size, .req_space, .req_write,
    .req_cache_inhibit, .req_first, .req_locked, .req_locked_last, .cache_hit(abort_in[0]),
    .translation_miss(abort_in[1]), .mapper_fault(abort_in[2]), .async_ack0_n, .async_ack1_n, .sync_terminate_n,
    .burst_ack_n, .cache_inhibit_in_n, .req_ready, .cycle_done, .cycle_aborted, .port_size, .ended_sync,
    .burst_granted, .inhibit_seen, .early_cycle_start_n, .operand_start_n, .address_strobe_n, .space_code,
    .xfer_size_lo, .xfer_size_hi, .read_write, .cache_inhibit_out_n, .locked_sequence_n, .addr_lines);
  bcs_port_model u_port (.core_clk, .address_strobe_n, .reply, .delay, .async_ack0_n, .async_ack1_n,
    .sync_terminate_n, .burst_ack_n, .cache_inhibit_in_n);
  // ==========
  // Checking helpers
  task chk(input [31:0] got, input [31:0] exp, input string m);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD %0t %s", $time, m);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Port width code expected from the far side's answer
  function [1:0] exp_port(input [2:0] r);
    exp_port = r[2] ? 2'h3 : ~r[1:0];
  endfunction
  // One request through start, then wait for its end
  task run(input [2:0] rep, input [2:0] ab, input fst, input lk, input lst);
    integer n, r;
    begin
      r = $random(seed);
      req_addr = $random(seed);
      {req_space, req_size, req_write, req_cache_inhibit, delay} = r[8:0];
      {req_first, req_locked, req_locked_last, reply, abort_in} = {fst, lk, lst, rep, ab};
      req_valid = 1'h1;
      @(negedge core_clk);
      chk(early_cycle_start_n, 0, "start strobe");
      chk(req_ready, 0, "busy after take");
      chk(operand_start_n, !fst, "operand strobe");
      chk(addr_lines, req_addr, "address");
      chk({space_code, xfer_size_hi, xfer_size_lo, read_write, cache_inhibit_out_n},
        {req_space, req_size, !req_write, !req_cache_inhibit}, "control");
      chk(locked_sequence_n, !lk, "lock at start");
      @(negedge core_clk);
      req_valid = 1'h0;
      chk(early_cycle_start_n, 1, "request refused while busy");
      n = 0;
      while ((cycle_done | cycle_aborted) !== 1'h1 && n < 40) begin
        @(negedge core_clk);
        n = n + 1;
      end
      if (n == 40) begin
        n_fail = n_fail + 1;
        end_of_test;
      end
      chk(cycle_aborted, ab != 3'h0, "abort");
      chk(req_ready, 1, "ready after end");
      if (ab == 3'h0) begin
        chk(port_size, exp_port(rep), "port width");
        chk(ended_sync, rep[2], "sync end");
        chk(burst_granted, rep[2], "burst ack seen");
        chk(inhibit_seen, rep[2], "inhibit in seen");
        chk(locked_sequence_n, !(lk && !lst), "lock at end");
      end
    end
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (3) @(negedge core_clk);
    reset_n = 1'h1;
    repeat (2) @(negedge core_clk);
    for (k = 0; k < 4; k = k + 1) run(k == 3 ? 3'h4 : 3'h2 - k[2:0], 3'h0, k[0], 1'h0, 1'h0);
    for (k = 0; k < 3; k = k + 1) run(3'h4, 3'h1 << k, 1'h1, 1'h0, 1'h0);
    $display("corner tests done");
    run(3'h0, 3'h0, 1'h1, 1'h1, 1'h0);
    run(3'h2, 3'h0, 1'h0, 1'h1, 1'h0);
    run(3'h4, 3'h0, 1'h0, 1'h1, 1'h1);
    run(3'h1, 3'h0, 1'h1, 1'h0, 1'h0);
    $display("lock tests done");
    for (k = 0; k < 40; k = k + 1) begin
      i = $random(seed);
      run(i[2] ? 3'h4 : {1'h0, i[1:0] == 2'h3 ? 2'h0 : i[1:0]}, i[5:4] == 2'h0 ? (i[8:6] | 3'h1) : 3'h0,
        i[9], i[10], i[11]);
    end
    $display("random tests done");
    end_of_test;
  end
endmodule
